// ==== rtl/gate_interlock.v ====
// Decision logic of a coded safety gate switch with magnetic guard locking.
// Assumes asynchronous pin inputs, one 200 MHz clock, and a two-channel evaluator downstream.
// Notes on behaviour
// R1: Both safety outputs high only with actuator, both inputs, lock command, force test passed.
// R2: Any single failing enabling condition drops both safety outputs.
// R3: Gate-closed output follows actuator presence only.
// R4: One input falling while the other stays high flags unequal status.
// R5: Fallen input returning while other stayed high flags error and locks out.
// R6: Safety outputs stay off throughout the partial-operation lock.
// R7: Lock clears only once both inputs have been low together.
// R8: Magnet energised with lock command high and actuator present, and while the power-up force test runs.
// R9: Holding-force test runs at power-up; pass is an enabling condition.
// R10: Controller keeps lock command low at least 500 ms before raising it.
// R11: Open or shorted winding while energised forces safety outputs low.
// R12: Gate forced open while locked shuts the safety outputs down.
// R13: Evaluator checks both outputs as two agreeing OSSD channels.
// R14: Gate, lock-green and input indicators show presence, locking, inputs high.
// R15: Input indicator flashes during partial operation.
// R16: Lock indicator red when locking requested but not achieved.
// R17: Internal fault lights fault red and flashes a code on the gate indicator.
// R18: Control and presence inputs synchronised and filtered before evaluation.
`include "gate_interlock_regs.vh"

module gate_interlock (
    input wire clk,
    input wire rst_n,
    input wire actuator_present,
    input wire safety_in_ch1,
    input wire safety_in_ch2,
    input wire lock_command_in,
    input wire force_ok,
    input wire winding_open,
    input wire winding_short,
    output reg safety_out_ch1,
    output reg safety_out_ch2,
    output reg gate_closed_out,
    output reg magnet_on,
    output reg unequal_flag,
    output reg feasibility_error,
    output reg led_power_green,
    output reg led_fault_red,
    output reg led_gate,
    output reg led_input,
    output reg led_lock_green,
    output reg led_lock_red
);
    // Partial-operation states
    localparam ST_NORMAL = 2'b00;
    localparam ST_UNEQUAL = 2'b01;
    localparam ST_LOCKOUT = 2'b10;
    // Holding-force test states
    localparam FT_IDLE = 2'b00;
    localparam FT_RUN = 2'b01;
    localparam FT_PASS = 2'b10;
    localparam FT_FAIL = 2'b11;
    // Terminal counts sized to their counters
    localparam [`CNT_W-1:0] FT_LAST = `FORCE_TEST_CYC - 1;
    localparam [`CNT_W-1:0] FLASH_LAST = `FLASH_HALF_CYC - 1;
    localparam [3:0] BLINK_ON = `FAULT_BLINKS;
    localparam [3:0] BLINK_WRAP = 2 * `FAULT_BLINKS;

    reg rst_meta_reg;
    reg rst_sync_reg;
    wire srst_n;
    wire act_f;
    wire in1_f;
    wire in2_f;
    wire lock_f;
    wire fok_f;
    wire wopen_f;
    wire wshort_f;
    reg in1_prev_reg;
    reg in2_prev_reg;
    reg [1:0] po_state_reg;
    reg [1:0] po_state_next;
    reg [1:0] ft_state_reg;
    reg [`CNT_W-1:0] ft_cnt_reg;
    reg fault_reg;
    reg [`CNT_W-1:0] flash_cnt_reg;
    reg flash_reg;
    reg [3:0] blink_cnt_reg;
    wire enable;
    wire magnet_next;

    ////////////////////////////////////////////////////////////////
    // Reset release through two flops
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign srst_n = rst_sync_reg;

    ////////////////////////////////////////////////////////////////
    // Every pin input is synchronised and filtered before use
    input_filter u_f_act (.clk(clk), .rst_n(srst_n), .din(actuator_present), .dout(act_f)); // see R18
    input_filter u_f_in1 (.clk(clk), .rst_n(srst_n), .din(safety_in_ch1), .dout(in1_f)); // see R18
    input_filter u_f_in2 (.clk(clk), .rst_n(srst_n), .din(safety_in_ch2), .dout(in2_f)); // see R18
    input_filter u_f_lock (.clk(clk), .rst_n(srst_n), .din(lock_command_in), .dout(lock_f)); // see R18
    input_filter u_f_fok (.clk(clk), .rst_n(srst_n), .din(force_ok), .dout(fok_f));
    input_filter u_f_wop (.clk(clk), .rst_n(srst_n), .din(winding_open), .dout(wopen_f));
    input_filter u_f_wsh (.clk(clk), .rst_n(srst_n), .din(winding_short), .dout(wshort_f));

    ////////////////////////////////////////////////////////////////
    // Partial-operation monitor on the two safety inputs
    always @* begin
        po_state_next = po_state_reg;
        case (po_state_reg)
            ST_NORMAL: begin
                if (in1_prev_reg && in2_prev_reg && (in1_f != in2_f)) begin
                    po_state_next = ST_UNEQUAL; // see R4
                end
            end
            ST_UNEQUAL: begin
                if (!in1_f && !in2_f) begin
                    po_state_next = ST_NORMAL;
                end else if (in1_f && in2_f) begin
                    po_state_next = ST_LOCKOUT; // see R5
                end
            end
            ST_LOCKOUT: begin
                if (!in1_f && !in2_f) begin
                    po_state_next = ST_NORMAL; // see R7
                end
            end
            default: po_state_next = ST_LOCKOUT;
        endcase
    end

    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            po_state_reg <= ST_NORMAL;
            in1_prev_reg <= 1'b0;
            in2_prev_reg <= 1'b0;
        end else begin
            po_state_reg <= po_state_next;
            in1_prev_reg <= in1_f;
            in2_prev_reg <= in2_f;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Power-up holding-force test: magnet is pulsed and force sensed
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            ft_state_reg <= FT_IDLE;
            ft_cnt_reg <= {`CNT_W{1'b0}};
        end else begin
            case (ft_state_reg)
                FT_IDLE: ft_state_reg <= FT_RUN;
                FT_RUN: begin
                    if (fok_f) begin
                        ft_state_reg <= FT_PASS; // see R9
                    end else if (ft_cnt_reg == FT_LAST) begin
                        ft_state_reg <= FT_FAIL;
                    end else begin
                        ft_cnt_reg <= ft_cnt_reg + 27'h1;
                    end
                end
                FT_PASS: ft_state_reg <= FT_PASS;
                FT_FAIL: ft_state_reg <= FT_FAIL;
                default: ft_state_reg <= FT_FAIL;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Winding fault is latched; only a reset clears it
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            fault_reg <= 1'b0;
        end else if (magnet_on && (wopen_f || wshort_f)) begin
            fault_reg <= 1'b1; // see R11
        end
    end

    // Magnet and enable decisions
    assign magnet_next = (lock_f && act_f) || (ft_state_reg == FT_RUN); // see R8
    // A forced-open gate drops act_f, which removes enable at once
    assign enable = act_f && in1_f && in2_f && lock_f && (ft_state_reg == FT_PASS) && !fault_reg
        && (po_state_reg != ST_LOCKOUT) && (po_state_next != ST_LOCKOUT); // see R1 see R2 see R6 see R12

    ////////////////////////////////////////////////////////////////
    // Flash timebase for indicators
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            flash_cnt_reg <= {`CNT_W{1'b0}};
            flash_reg <= 1'b0;
            blink_cnt_reg <= 4'h0;
        end else if (flash_cnt_reg == FLASH_LAST) begin
            flash_cnt_reg <= {`CNT_W{1'b0}};
            flash_reg <= ~flash_reg;
            if (flash_reg) begin
                blink_cnt_reg <= (blink_cnt_reg == BLINK_WRAP) ? 4'h0 : blink_cnt_reg + 4'h1;
            end
        end else begin
            flash_cnt_reg <= flash_cnt_reg + 27'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // All outputs registered
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            safety_out_ch1 <= 1'b0;
            safety_out_ch2 <= 1'b0;
            gate_closed_out <= 1'b0;
            magnet_on <= 1'b0;
            unequal_flag <= 1'b0;
            feasibility_error <= 1'b0;
            led_power_green <= 1'b0;
            led_fault_red <= 1'b0;
            led_gate <= 1'b0;
            led_input <= 1'b0;
            led_lock_green <= 1'b0;
            led_lock_red <= 1'b0;
        end else begin
            safety_out_ch1 <= enable; // see R1 see R2
            safety_out_ch2 <= enable; // see R1 see R2
            gate_closed_out <= act_f; // see R3
            magnet_on <= magnet_next; // see R8
            unequal_flag <= (po_state_reg == ST_UNEQUAL); // see R4
            feasibility_error <= (po_state_reg == ST_LOCKOUT); // see R5
            led_power_green <= !fault_reg && (ft_state_reg != FT_FAIL);
            led_fault_red <= fault_reg || (ft_state_reg == FT_FAIL); // see R17
            // Fault code: bursts of blinks then a gap, on the gate indicator
            if (fault_reg || ft_state_reg == FT_FAIL) begin
                led_gate <= flash_reg && (blink_cnt_reg < BLINK_ON); // see R17
            end else begin
                led_gate <= act_f; // see R14
            end
            if (po_state_reg != ST_NORMAL) begin
                led_input <= flash_reg; // see R15
            end else begin
                led_input <= in1_f && in2_f; // see R14
            end
            led_lock_green <= magnet_on && act_f; // see R14
            led_lock_red <= lock_f && !(magnet_on && act_f && ft_state_reg == FT_PASS); // see R16
        end
    end
endmodule // gate_interlock

// ==== rtl/gate_interlock_regs.vh ====
// Timing constants for the safety gate interlock decision logic.
// Assumes a 200 MHz system clock; included by its bare name.
`ifndef GATE_INTERLOCK_REGS_VH
`define GATE_INTERLOCK_REGS_VH
// Clock period in ns
`define CLK_PERIOD_NS 5
// Input filter: samples that must agree before a level is accepted
`define FILT_LEN 4
`define FILT_CNT_W 3
// Indicator flash half period in ms and in cycles
`define FLASH_HALF_MS 250
`define FLASH_HALF_CYC ((`FLASH_HALF_MS * 1000000) / `CLK_PERIOD_NS)
// Magnet holding-force test duration in ms and in cycles
`define FORCE_TEST_MS 100
`define FORCE_TEST_CYC ((`FORCE_TEST_MS * 1000000) / `CLK_PERIOD_NS)
// Fault flash code: number of blinks per burst
`define FAULT_BLINKS 3
`define CNT_W 27
`endif

// ==== rtl/input_filter.v ====
// Two-flop synchroniser followed by an agreement filter.
// Assumes the input is asynchronous to clk; output changes only after FILT_LEN equal samples.
`include "gate_interlock_regs.vh"

module input_filter (
    input wire clk,
    input wire rst_n,
    input wire din,
    output reg dout
);
    reg meta_reg;
    reg sync_reg;
    reg [`FILT_CNT_W-1:0] cnt_reg;
    // Terminal count sized to the counter so the compare stays width-clean
    localparam [`FILT_CNT_W-1:0] FILT_LAST = `FILT_LEN - 1;

    ////////////////////////////////////////////////////////////////
    // First flop feeds only the second; filter looks at sync_reg
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            cnt_reg <= {`FILT_CNT_W{1'b0}};
            dout <= 1'b0;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
            if (sync_reg == dout) begin
                cnt_reg <= {`FILT_CNT_W{1'b0}};
            end else if (cnt_reg == FILT_LAST) begin
                cnt_reg <= {`FILT_CNT_W{1'b0}};
                dout <= sync_reg; // Glitches shorter than the window never pass
            end else begin
                cnt_reg <= cnt_reg + 3'h1;
            end
        end
    end
endmodule // input_filter

// ==== bench/safety_evaluator_model.sv ====
// Two-channel evaluator standing downstream of the interlock safety outputs.
// Assumes both channels arrive on the interlock clock; reset is active low.
module safety_evaluator_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ch1,
    input wire logic ch2,
    output logic enable_reg,
    output logic disagree_reg
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////////////////////////////////////
    // Disagreement latches so a single glitch cannot be masked by recovery
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            disagree_reg <= 1'b0;
            enable_reg <= 1'b0;
        end else begin
            disagree_reg <= disagree_reg | (ch1 != ch2);
            enable_reg <= ch1 & ch2 & ~disagree_reg;
        end
    end
endmodule // safety_evaluator_model

// ==== bench/gate_interlock_assertions.sv ====
// Temporal checks on the interlock ports.
// Assumes one clock domain; pins are asynchronous and pass a sync and filter stage.
module gate_interlock_assertions (
    input wire clk,
    input wire rst_n,
    input wire actuator_present,
    input wire safety_in_ch1,
    input wire safety_in_ch2,
    input wire lock_command_in,
    input wire safety_out_ch1,
    input wire safety_out_ch2,
    input wire gate_closed_out,
    input wire magnet_on,
    input wire unequal_flag,
    input wire feasibility_error,
    input wire led_fault_red
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // Sixteen stable cycles cover reset release, sync, filter and register
    property p_outs_agree; safety_out_ch1 == safety_out_ch2; endproperty
    a_outs_agree: assert property (p_outs_agree) else $error("safety outputs differ");
    property p_gate_high; actuator_present [*8] ##1 actuator_present [*8] |-> gate_closed_out; endproperty
    a_gate_high: assert property (p_gate_high) else $error("gate output missed presence");
    property p_gate_low; !actuator_present [*8] ##1 !actuator_present [*8] |-> !gate_closed_out; endproperty
    a_gate_low: assert property (p_gate_low) else $error("gate output without presence");
    property p_forced_open; $fell(gate_closed_out) |-> ##[0:1] !safety_out_ch1; endproperty
    a_forced_open: assert property (p_forced_open) else $error("outputs stayed on after gate opened");
    property p_input_low; !safety_in_ch2 [*8] ##1 !safety_in_ch2 [*8] |-> !safety_out_ch1; endproperty
    a_input_low: assert property (p_input_low) else $error("outputs on with input low");
    property p_lock_low; !lock_command_in [*8] ##1 !lock_command_in [*8] |-> !safety_out_ch2; endproperty
    a_lock_low: assert property (p_lock_low) else $error("outputs on with lock command low");
    property p_lockout_off; feasibility_error [*2] |-> !safety_out_ch1 && !safety_out_ch2; endproperty
    a_lockout_off: assert property (p_lockout_off) else $error("outputs on during lockout");
    property p_fault_off; led_fault_red |=> !safety_out_ch1 && !safety_out_ch2; endproperty
    a_fault_off: assert property (p_fault_off) else $error("outputs on during fault");
    property p_both_low_clear;
        (!safety_in_ch1 && !safety_in_ch2) [*8] ##1 (!safety_in_ch1 && !safety_in_ch2) [*8] |-> !feasibility_error;
    endproperty
    a_both_low_clear: assert property (p_both_low_clear) else $error("lockout kept after both low");
    property p_out_magnet; safety_out_ch1 [*2] |-> magnet_on; endproperty
    a_out_magnet: assert property (p_out_magnet) else $error("outputs on without magnet");
    c_enabled: cover property (safety_out_ch1 && safety_out_ch2);
    c_unequal: cover property (unequal_flag);
    c_lockout: cover property (feasibility_error);
    c_fault: cover property (led_fault_red);
endmodule // gate_interlock_assertions
bind gate_interlock gate_interlock_assertions i_chk (.clk(clk), .rst_n(rst_n), .actuator_present(actuator_present),
    .safety_in_ch1(safety_in_ch1), .safety_in_ch2(safety_in_ch2), .lock_command_in(lock_command_in),
    .safety_out_ch1(safety_out_ch1), .safety_out_ch2(safety_out_ch2), .gate_closed_out(gate_closed_out),
    .magnet_on(magnet_on), .unequal_flag(unequal_flag), .feasibility_error(feasibility_error),
    .led_fault_red(led_fault_red));

// ==== bench/test_gate_interlock.sv ====
// Self-checking bench for the interlock decision logic.
// Assumes force_ok answers the power-up test at once, except where a scenario holds it back.
module test_gate_interlock;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_n, act, in1, in2, lck, fok, wopen, wshort;
    wire so1, so2, gco, mag, uneq, ferr, fr, enable, disagree;
    wire lpg, lg, li, llg, llr;
    int error_cnt, checked;
    gate_interlock i_dut (.clk(clk), .rst_n(rst_n), .actuator_present(act), .safety_in_ch1(in1),
        .safety_in_ch2(in2), .lock_command_in(lck), .force_ok(fok), .winding_open(wopen), .winding_short(wshort),
        .safety_out_ch1(so1), .safety_out_ch2(so2), .gate_closed_out(gco), .magnet_on(mag), .unequal_flag(uneq),
        .feasibility_error(ferr), .led_power_green(lpg), .led_fault_red(fr), .led_gate(lg), .led_input(li),
        .led_lock_green(llg), .led_lock_red(llr));
    safety_evaluator_model i_eval (.clk(clk), .rst_n(rst_n), .ch1(so1), .ch2(so2), .enable_reg(enable),
        .disagree_reg(disagree));
    ////////////////////////////////////////////////////////////////////////
    // Clock and shared helpers
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic complete_run;
        if (error_cnt == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic seen, input logic exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %b expected %b", $time, seen, exp);
        end
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: pick = gco;
            1: pick = uneq;
            2: pick = ferr;
            3: pick = fr;
            default: pick = so1;
        endcase
    endfunction
    // Bounded wait sampled on the falling edge, away from the launch edge
    task automatic wait_out(input int sel, input logic v);
        int n;
        n = 0;
        while (pick(sel) !== v && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (n == 40) begin
            error_cnt++;
            $display("ERROR at %0t: output %0d never reached %b", $time, sel, v);
            complete_run();
        end
    endtask
    task automatic drive(input logic a, input logic i1, input logic i2);
        @(posedge clk);
        act <= a;
        in1 <= i1;
        in2 <= i2;
    endtask
    // Fixed wait of 14 cycles, to let outputs follow a change or to prove that nothing moves
    task automatic settle;
        repeat (14) @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_gate;
        drive(1'b1, 1'b1, 1'b1);
        wait_out(0, 1'b1);
        check(gco, 1'b1);
        settle();
        check(mag, 1'b1);
        check(so1, 1'b1);
        check(enable, 1'b1);
        check(lg, 1'b1);
        check(li, 1'b1);
        check(llg, 1'b1);
        check(lpg, 1'b1);
        drive(1'b0, 1'b1, 1'b1);
        wait_out(0, 1'b0);
        check(so2, 1'b0);
        check(so1, 1'b0);
        drive(1'b1, 1'b1, 1'b1);
        drive(1'b0, 1'b1, 1'b1);
        settle();
        check(gco, 1'b0);
        check(mag, 1'b0);
        check(llr, 1'b1);
    endtask
    task automatic t_lockout;
        drive(1'b1, 1'b1, 1'b1);
        settle();
        drive(1'b1, 1'b1, 1'b0);
        wait_out(1, 1'b1);
        check(uneq, 1'b1);
        drive(1'b1, 1'b1, 1'b1);
        wait_out(2, 1'b1);
        check(ferr, 1'b1);
        settle();
        check(so1, 1'b0);
        check(li, 1'b0);
        drive(1'b1, 1'b0, 1'b0);
        wait_out(2, 1'b0);
        settle();
        check(so1, 1'b0);
        drive(1'b1, 1'b1, 1'b1);
        settle();
        check(ferr, 1'b0);
        check(so1, 1'b1);
        drive(1'b1, 1'b0, 1'b1);
        wait_out(1, 1'b1);
        drive(1'b1, 1'b0, 1'b0);
        wait_out(1, 1'b0);
        drive(1'b1, 1'b1, 1'b1);
        settle();
        check(ferr, 1'b0);
    endtask
    task automatic t_winding;
        @(posedge clk);
        wshort <= 1'b1;
        wait_out(3, 1'b1);
        @(posedge clk);
        wshort <= 1'b0;
        settle();
        check(fr, 1'b1);
        check(so1, 1'b0);
        check(lg, 1'b0);
        check(lpg, 1'b0);
        @(posedge clk);
        rst_n <= 1'b0;
        wopen <= 1'b1;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        wait_out(3, 1'b1);
        check(so2, 1'b0);
        check(disagree, 1'b0);
    endtask
    // Fresh power-up with the force test held back, then the lock command drops for good
    task automatic t_lock;
        @(posedge clk);
        rst_n <= 1'b0;
        wopen <= 1'b0;
        fok <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        wait_out(0, 1'b1);
        settle();
        check(so1, 1'b0);
        check(mag, 1'b1);
        check(fr, 1'b0);
        @(posedge clk);
        fok <= 1'b1;
        wait_out(4, 1'b1);
        check(so2, 1'b1);
        @(posedge clk);
        lck <= 1'b0;
        wait_out(4, 1'b0);
        check(mag, 1'b0);
        check(gco, 1'b1);
        check(so2, 1'b0);
        settle();
        check(llr, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence; lock command drops only in the last scenario and never rises again
    initial begin
        error_cnt = 0;
        checked = 0;
        rst_n = 1'b0;
        act = 1'b0;
        in1 = 1'b0;
        in2 = 1'b0;
        lck = 1'b1;
        fok = 1'b1;
        wopen = 1'b0;
        wshort = 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_gate();
        t_lockout();
        t_winding();
        t_lock();
        complete_run();
    end
endmodule // test_gate_interlock
